// ==== tap_decode_pkg.sv ====
// Package of constants and types for the test access port decoder
`default_nettype none

package tap_decode_pkg;

  // ****************************************
  // Scan register sizes
  // ****************************************
  localparam int unsigned IR_LEN  = 3;   // Instruction register bits
  localparam int unsigned ID_LEN  = 32;  // Identification register bits
  localparam int unsigned BSR_LEN = 68;  // Boundary scan register bits

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [2:0] INS_CAPTURE_HIZ = 3'h0;  // Capture ring, outputs off
  localparam logic [2:0] INS_IDENT       = 3'h1;  // Identification word
  localparam logic [2:0] INS_SAMPLE_HIZ  = 3'h2;  // Sample ring, outputs off
  localparam logic [2:0] INS_SAMPLE      = 3'h4;  // Sample ring, no disturbance
  localparam logic [2:0] INS_BYPASS      = 3'h7;  // One-bit bypass

  // Capture-IR load value; two low bits fixed at 01
  localparam logic [2:0] IR_CAPTURE_VAL  = 3'h1;
  // Bypass register capture value
  localparam logic       BYPASS_CAP_VAL  = 1'h0;

  // ****************************************
  // Types
  // ****************************************
  // Identification word fields, msb first
  typedef struct packed {
    logic [3:0]  version_field;      // Bits 31:28
    logic [4:0]  depth_field;        // Bits 27:23
    logic [4:0]  width_field;        // Bits 22:18
    logic [5:0]  part_number_field;  // Bits 17:12
    logic [10:0] maker_code_field;   // Bits 11:1
    logic        present;            // Bit 0
  } id_word_t;

  // Which scan register sits between serial in and out
  typedef enum logic [2:0] {
    SEL_BYPASS = 3'h1,
    SEL_IDENT  = 3'h2,
    SEL_BSR    = 3'h4
  } dr_sel_t;

  // Sixteen controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET   = 16'h0001, ST_IDLE    = 16'h0002,
    ST_SEL_DR  = 16'h0004, ST_CAP_DR  = 16'h0008,
    ST_SH_DR   = 16'h0010, ST_EX1_DR  = 16'h0020,
    ST_PAU_DR  = 16'h0040, ST_EX2_DR  = 16'h0080,
    ST_UPD_DR  = 16'h0100, ST_SEL_IR  = 16'h0200,
    ST_CAP_IR  = 16'h0400, ST_SH_IR   = 16'h0800,
    ST_EX1_IR  = 16'h1000, ST_PAU_IR  = 16'h2000,
    ST_EX2_IR  = 16'h4000, ST_UPD_IR  = 16'h8000
  } tap_state_t;

endpackage : tap_decode_pkg

`default_nettype wire

// ==== boundary_scan_tap_decode.sv ====
// Test access port controller, instruction decode and scan registers
`default_nettype none

module boundary_scan_tap_decode
  import tap_decode_pkg::*;
#(
  parameter logic [3:0]  VERSION_VAL = 4'h0,    // Arbitrary value
  parameter logic [4:0]  DEPTH_VAL   = 5'h05,   // Arbitrary value
  parameter logic [4:0]  WIDTH_VAL   = 5'h09,   // Arbitrary value
  parameter logic [5:0]  PART_VAL    = 6'h00,   // Arbitrary value
  parameter logic [10:0] MAKER_VAL   = 11'h2a5  // Arbitrary value
)(
  // System clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  // Test link
  input  wire logic               tck_in,
  input  wire logic               tms_in,
  input  wire logic               tdi_in,
  output logic                    tdo_out,
  output logic                    tdo_oe_out,
  // SRAM side
  input  wire logic [BSR_LEN-1:0] ring_in,
  output logic                    sram_hiz_out
);

  // ****************************************
  // Decode functions
  // ****************************************
  // Scan register chosen by an instruction
  function automatic dr_sel_t sel_of(input logic [2:0] ins);
    unique case (ins)
      INS_IDENT:                               sel_of = SEL_IDENT;
      INS_CAPTURE_HIZ, INS_SAMPLE_HIZ, INS_SAMPLE: sel_of = SEL_BSR;
      default:                                 sel_of = SEL_BYPASS;
    endcase
  endfunction : sel_of

  // Instructions that turn SRAM outputs off
  function automatic logic hiz_of(input logic [2:0] ins);
    hiz_of = (ins == INS_CAPTURE_HIZ) || (ins == INS_SAMPLE_HIZ);
  endfunction : hiz_of

  // ****************************************
  // Link-side state
  // ****************************************
  tap_state_t            state;        // Controller state
  tap_state_t            next_state;
  logic [IR_LEN-1:0]     ir;           // Active instruction
  logic [IR_LEN-1:0]     next_ir;
  logic [IR_LEN-1:0]     ir_sh;        // Instruction shifter
  logic [IR_LEN-1:0]     next_ir_sh;
  logic                  byp;          // Bypass bit
  logic                  next_byp;
  logic [ID_LEN-1:0]     id_sh;        // Identification shifter
  logic [ID_LEN-1:0]     next_id_sh;
  logic [BSR_LEN-1:0]    bsr_sh;       // Boundary scan shifter
  logic [BSR_LEN-1:0]    next_bsr_sh;
  logic [BSR_LEN-1:0]    ring_meta;    // Ring synchroniser, first stage
  logic [BSR_LEN-1:0]    ring_s;       // Ring synchroniser, second stage
  logic                  tdo_q;        // Falling-edge output data
  logic                  next_tdo;
  logic                  oe_q;         // Falling-edge output enable
  logic                  next_oe;
  dr_sel_t               sel;          // Current data register choice
  id_word_t              id_word;      // Fixed identification value
  logic                  hiz_tck;      // Outputs-off request, registered
  logic                  next_hiz;

  // ****************************************
  // Identification word
  // ****************************************
  always_comb
  begin
    id_word.version_field     = VERSION_VAL;
    id_word.depth_field       = DEPTH_VAL;
    id_word.width_field       = WIDTH_VAL;
    id_word.part_number_field = PART_VAL;
    id_word.maker_code_field  = MAKER_VAL;
    id_word.present           = 1'h1;
  end

  assign sel     = sel_of(ir);

  // ****************************************
  // Controller next state
  // ****************************************
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_RESET:  next_state = tms_in ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_state = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms_in ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms_in ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_state = tms_in ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_state = tms_in ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms_in ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms_in ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_state = tms_in ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_state = tms_in ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms_in ? ST_SEL_DR : ST_IDLE;
      default:   next_state = ST_RESET;  // Illegal code recovers
    endcase
  end

  // ****************************************
  // Instruction and data register next values
  // ****************************************
  always_comb
  begin
    next_ir     = ir;
    next_ir_sh  = ir_sh;
    next_byp    = byp;
    next_id_sh  = id_sh;
    next_bsr_sh = bsr_sh;
    // Instruction path
    if (state == ST_RESET)
      next_ir = INS_IDENT;
    else if (state == ST_UPD_IR)
      next_ir = ir_sh;
    if (state == ST_CAP_IR)
      next_ir_sh = IR_CAPTURE_VAL;
    else if (state == ST_SH_IR)
      next_ir_sh = {tdi_in, ir_sh[IR_LEN-1:1]};
    // Data path, only the chosen register moves
    if (state == ST_CAP_DR)
    begin
      unique case (sel)
        SEL_IDENT: next_id_sh  = id_word;
        SEL_BSR:   next_bsr_sh = ring_s;
        default:   next_byp    = BYPASS_CAP_VAL;
      endcase
    end
    else if (state == ST_SH_DR)
    begin
      unique case (sel)
        SEL_IDENT: next_id_sh  = {tdi_in, id_sh[ID_LEN-1:1]};
        SEL_BSR:   next_bsr_sh = {tdi_in, bsr_sh[BSR_LEN-1:1]};
        default:   next_byp    = tdi_in;
      endcase
    end
    // Update-DR has no preload effect
    next_hiz = hiz_of(next_ir);
  end

  // ****************************************
  // Serial output next value, lsb nearest out
  // ****************************************
  always_comb
  begin
    next_oe  = (state == ST_SH_DR) || (state == ST_SH_IR);
    next_tdo = 1'h0;
    if (state == ST_SH_IR)
      next_tdo = ir_sh[0];
    else if (state == ST_SH_DR)
    begin
      unique case (sel)
        SEL_IDENT: next_tdo = id_sh[0];
        SEL_BSR:   next_tdo = bsr_sh[0];
        default:   next_tdo = byp;
      endcase
    end
  end

  // ****************************************
  // Rising-edge link registers
  // ****************************************
  always_ff @(posedge tck_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state     <= ST_RESET;
      ir        <= INS_IDENT;
      ir_sh     <= IR_CAPTURE_VAL;
      byp       <= BYPASS_CAP_VAL;
      id_sh     <= '0;
      bsr_sh    <= '0;
      ring_meta <= '0;
      ring_s    <= '0;
      hiz_tck   <= 1'h0;
    end
    else
    begin
      state     <= next_state;
      ir        <= next_ir;
      ir_sh     <= next_ir_sh;
      byp       <= next_byp;
      id_sh     <= next_id_sh;
      bsr_sh    <= next_bsr_sh;
      ring_meta <= ring_in;
      ring_s    <= ring_meta;
      hiz_tck   <= next_hiz;  // Flop output, no decode glitch crosses
    end
  end

  // ****************************************
  // Falling-edge output registers
  // ****************************************
  always_ff @(negedge tck_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tdo_q <= 1'h0;
      oe_q  <= 1'h0;
    end
    else
    begin
      tdo_q <= next_tdo;
      oe_q  <= next_oe;
    end
  end

  assign tdo_out    = tdo_q;
  assign tdo_oe_out = oe_q;

  // ****************************************
  // Outputs-off level into system clock domain
  // ****************************************
  logic hiz_meta;  // First stage, read only by second
  logic hiz_sync;  // Second stage

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      hiz_meta <= 1'h0;
      hiz_sync <= 1'h0;
    end
    else
    begin
      hiz_meta <= hiz_tck;
      hiz_sync <= hiz_meta;
    end
  end

  assign sram_hiz_out = hiz_sync;

  // ****************************************
  // Checks
  // ****************************************
  sequence seq_cap_ident;
    (state == ST_CAP_DR) && (sel == SEL_IDENT);
  endsequence

  sequence seq_id_shift;
    (state == ST_SH_DR) && (sel == SEL_IDENT);
  endsequence

  chk_reset_ident: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    (state == ST_RESET) |=> (ir == INS_IDENT))
    else $error("Reset state did not load identification instruction");

  chk_capir_pattern: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    (state == ST_CAP_IR) |=> (ir_sh[1:0] == 2'h1))
    else $error("Capture-IR did not load 01");

  chk_five_tms: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    tms_in [*5] |=> (state == ST_RESET))
    else $error("Five high mode-select edges did not reset");

  chk_update_ir: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    (state == ST_UPD_IR) |=> (ir == $past(ir_sh)))
    else $error("Update-IR did not take shifted instruction");

  chk_id_capture: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    seq_cap_ident ##1 seq_id_shift |-> (id_sh[0] == 1'h1) && (id_sh[31:28] == VERSION_VAL))
    else $error("Identification word not captured");

  chk_id_lsb_out: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    seq_id_shift ##1 (state == ST_SH_DR) |-> (tdo_q == id_sh[0]))
    else $error("Serial output did not carry current lsb");

  chk_hiz_codes: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    (ir == INS_CAPTURE_HIZ || ir == INS_SAMPLE_HIZ) |-> hiz_tck && (sel == SEL_BSR))
    else $error("Outputs-off instruction not decoded");

  chk_no_hiz: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    (ir == INS_IDENT || ir == INS_SAMPLE || ir == INS_BYPASS) |-> !hiz_tck)
    else $error("Outputs turned off by a non-disturbing instruction");

  chk_bsr_capture: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    (state == ST_CAP_DR) && (sel == SEL_BSR) |=> (bsr_sh == $past(ring_s)))
    else $error("Boundary register did not capture ring");

  chk_bypass_cap: assert property (
    @(posedge tck_in) disable iff (!rst_b_in)
    (state == ST_CAP_DR) && (ir == INS_BYPASS) |=> (byp == 1'h0))
    else $error("Bypass bit not cleared at capture");

  chk_hiz_reach: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    hiz_tck [*2] |=> sram_hiz_out)
    else $error("Outputs-off level did not cross");

  chk_hiz_release: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (!hiz_tck) [*2] |=> !sram_hiz_out)
    else $error("Outputs-off level did not clear");

endmodule : boundary_scan_tap_decode

`default_nettype wire

// ==== scan_controller_model.sv ====
// Model of the external boundary-scan controller on the test link
`default_nettype none

module scan_controller_model
  import tap_decode_pkg::*;
(
  // Test link
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****
  // Link drive
  // ****
  // Clock stands still low between frames
  initial
  begin
    tck_out = 1'h0;
    tms_out = 1'h1;
    tdi_out = 1'h0;
  end

  // One 12 ns link clock; sample serial out at the rise
  task automatic clock_bit(input logic tms_v, input logic tdi_v,
                           output logic tdo_v, output logic oe_v);
    tms_out = tms_v;
    tdi_out = tdi_v;
    #3;
    tck_out = 1'h1;
    tdo_v   = tdo_in;
    oe_v    = tdo_oe_in;
    #6;
    tck_out = 1'h0;
    #3;
  endtask : clock_bit

  // Step the controller; data line shows no stale value
  task automatic nav(input logic tms_v);
    logic d;
    logic o;
    clock_bit(tms_v, ~tdi_out, d, o);
  endtask : nav

  // Five high mode-select edges, then idle
  task automatic reset_tap();
    repeat (5) nav(1'h1);
    nav(1'h0);
  endtask : reset_tap

  // From idle: shift n bits lsb first, update, back to idle
  task automatic shift_reg(input logic to_ir, input int unsigned n,
                           input logic [BSR_LEN-1:0] din,
                           output logic [BSR_LEN-1:0] dout, output logic oe_all);
    logic d;
    logic o;
    dout   = '0;
    oe_all = 1'h1;
    nav(1'h1);
    if (to_ir)
      nav(1'h1);
    nav(1'h0);
    nav(1'h0);
    for (int i = 0; i < n; i++)
    begin
      clock_bit(i == n - 1, din[i], d, o);
      dout[i] = d;
      oe_all  = oe_all & o;
    end
    nav(1'h1);
    nav(1'h0);
  endtask : shift_reg

endmodule : scan_controller_model

`default_nettype wire

// ==== boundary_scan_tap_decode_tb.sv ====
// Testbench of the test access port decoder
`default_nettype none

module boundary_scan_tap_decode_tb
  import tap_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****
  // Setup
  // ****
  localparam logic [3:0]  VER = 4'h3;    // Arbitrary value
  localparam logic [4:0]  DEP = 5'h0c;   // Arbitrary value
  localparam logic [4:0]  WID = 5'h11;   // Arbitrary value
  localparam logic [5:0]  PRT = 6'h15;   // Arbitrary value
  localparam logic [10:0] MKR = 11'h1b6; // Arbitrary value
  localparam logic [31:0] IDW = {VER, DEP, WID, PRT, MKR, 1'h1};
  localparam logic [BSR_LEN-1:0] PIN = 68'h5_9e37_79b9_7f4a_7c15;
  localparam int CEIL = 20000;           // Cycle ceiling

  logic               clk_in = 1'h0;
  logic               rst_b_in;
  logic               tck;
  logic               tms;
  logic               tdi;
  logic               tdo;
  logic               tdo_oe;
  logic               hiz;
  logic [BSR_LEN-1:0] ring;
  logic [BSR_LEN-1:0] got;
  logic [BSR_LEN-1:0] exp_v;
  logic               oe_ok;
  logic [2:0]         code;
  int                 n_errors = 0;
  int                 total_checks = 0;
  int                 cycles = 0;

  boundary_scan_tap_decode #(.VERSION_VAL(VER), .DEPTH_VAL(DEP), .WIDTH_VAL(WID),
    .PART_VAL(PRT), .MAKER_VAL(MKR)) boundary_scan_tap_decode_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .ring_in(ring),
    .sram_hiz_out(hiz));

  scan_controller_model scan_controller_model_i (
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo),
    .tdo_oe_in(tdo_oe));

  // ****
  // Helpers
  // ****
  always #2 clk_in = ~clk_in;

  // Cut a hang short
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input string name, input logic [BSR_LEN-1:0] seen,
                       input logic [BSR_LEN-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // Settle, then check the output-off level
  task automatic check_hiz(input logic exp);
    repeat (5) @(posedge clk_in);
    #1;
    check("sram_hiz", hiz, exp);
  endtask : check_hiz

  // Read the identification path after a reset of either kind
  task automatic read_id();
    scan_controller_model_i.shift_reg(1'h0, BSR_LEN, PIN, got, oe_ok);
    check("id_path", got, {PIN[35:0], IDW});
    check("tdo_oe", oe_ok, 1'h1);
    check("idle_tdo", {tdo, tdo_oe}, 2'h0);
    check_hiz(1'h0);
  endtask : read_id

  // ****
  // Sequence
  // ****
  initial
  begin
    rst_b_in = 1'h0;
    ring     = '0;
    fork
      scan_controller_model_i.nav(1'h1);
      repeat (6) @(posedge clk_in);
    join
    #1;
    rst_b_in = 1'h1;
    scan_controller_model_i.nav(1'h0);
    read_id();
    // Every usable code; reserved codes are never loaded
    for (int c = 0; c < 8; c++)
    begin
      code = c[2:0];
      if (code == 3'h3 || code == 3'h5 || code == 3'h6)
        continue;
      ring = {4'h9 ^ {1'h0, code}, 64'h0123_4567_89ab_cdef};
      scan_controller_model_i.shift_reg(1'h1, IR_LEN, {65'h0, code}, got, oe_ok);
      check("ir_capture", got[1:0], 2'h1);
      check_hiz(code == INS_CAPTURE_HIZ || code == INS_SAMPLE_HIZ);
      case (code)
        INS_CAPTURE_HIZ, INS_SAMPLE_HIZ, INS_SAMPLE: exp_v = ring;
        INS_IDENT: exp_v = {PIN[35:0], IDW};
        default: exp_v = {PIN[BSR_LEN-2:0], BYPASS_CAP_VAL};
      endcase
      scan_controller_model_i.shift_reg(1'h0, BSR_LEN, PIN, got, oe_ok);
      check("dr_path", got, exp_v);
    end
    // Mode-select reset clears outputs-off code
    scan_controller_model_i.shift_reg(1'h1, IR_LEN, {65'h0, INS_CAPTURE_HIZ}, got, oe_ok);
    check_hiz(1'h1);
    scan_controller_model_i.reset_tap();
    read_id();
    // Asynchronous reset in mid-run
    scan_controller_model_i.shift_reg(1'h1, IR_LEN, {65'h0, INS_SAMPLE_HIZ}, got, oe_ok);
    check_hiz(1'h1);
    @(posedge clk_in);
    #1;
    rst_b_in = 1'h0;
    fork
      scan_controller_model_i.nav(1'h1);
      repeat (6) @(posedge clk_in);
    join
    check("reset_outs", {tdo, tdo_oe, hiz}, 3'h0);
    #1;
    rst_b_in = 1'h1;
    scan_controller_model_i.nav(1'h0);
    read_id();
    stop_test();
  end

endmodule : boundary_scan_tap_decode_tb

`default_nettype wire
